// [rtl/ddslc_pkg.sv]
// Constants and carrier types for the dual converter serial load control.
// Assumes a single system clock domain plus a serial link clock from the host.
// Notes on behaviour
// - The 16-bit word arrives MSB first: bit 15 mode, bit 14 address B, bit 13 address A, bit 12 unused, bits 11..0 code.
// - Serial input is sampled into the shift word on each rising serial clock edge while chip select is low.
// - With chip select high the shift word holds, and chip select never affects the load strobes.
// - A falling edge of a load strobe copies the 12 data bits into the selected converter registers.
// - In hardware mode strobe A loads register A, strobe B loads register B, both load both, none loads nothing.
// - In software mode any strobe edge loads the registers named by the address bits, none when both are clear.
// - The serial output always carries the last stage of the shift word.
// - Each enabled rising edge shifts one bit, so the output repeats the input 16 clocks later.
// - Reset low with midscale select low clears both converter registers to zero asynchronously.
// - Reset low with midscale select high presets both registers to half scale; reset high does nothing.
package ddslc_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned MODE_BIT = 15;
  localparam int unsigned ADDR_B_BIT = 14;
  localparam int unsigned ADDR_A_BIT = 13;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_HALF = 12'h800;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic mode;
    logic addr_b;
    logic addr_a;
    logic spare;
    logic [11:0] code;
  } ddslc_word_s;

  typedef struct packed {
    logic load_a;
    logic load_b;
  } ddslc_sel_s;
endpackage : ddslc_pkg

// [rtl/ddslc_top.sv]
// Serial shift word on the link clock and two converter registers on the system clock.
// The word crosses into the system clock through a capture taken on a synchronised strobe edge.
// Assumes the host keeps the shift word still while a strobe is low.
// Assumes the preset and select pins may change at any time relative to the system clock.
`timescale 1ns/1ps
`default_nettype none
module ddslc_top
  import ddslc_pkg::*;
(
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Serial link
  input wire logic i_clk_link,
  input wire logic i_cs_n,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  // Load strobes and preset
  input wire logic i_load_strobe_a_n,
  input wire logic i_load_strobe_b_n,
  input wire logic i_preset_reset_n,
  input wire logic i_midscale_sel,
  // Converter codes
  output logic [11:0] o_conv_reg_a,
  output logic [11:0] o_conv_reg_b
);

  // Link domain: the host's shift word
  logic shift_en;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;

  // System domain reset, released on the clock
  logic rst_meta_reg;
  logic sys_rst_n_reg;

  // Pin synchronisers, first and second stage
  logic meta_a_reg;
  logic sync_a_reg;
  logic meta_b_reg;
  logic sync_b_reg;
  logic meta_pre_reg;
  logic sync_pre_reg;
  logic meta_mid_reg;
  logic sync_mid_reg;

  // Strobe history for edge detection
  logic hist_a_reg;
  logic hist_b_reg;

  // Captured word and the edges that go with it
  logic [15:0] word_cap_reg;
  logic [15:0] word_cap_next;
  logic pend_a_reg;
  logic pend_b_reg;

  // Decode
  ddslc_word_s word_view;
  ddslc_sel_s sel;
  logic fall_a;
  logic fall_b;
  logic fall_any;
  logic pend_any;
  logic hw_mode;
  logic sw_load_a;
  logic sw_load_b;
  logic [1:0] load_vec;

  // Preset
  logic clr_n;
  logic preset_active;
  logic [11:0] preset_code;

  // Converter registers, one per channel
  wire logic [11:0] conv_q [2];

  // Chip select gates the shift only
  assign shift_en = ~i_cs_n;

  assign shift_next = shift_en ? {shift_reg[WORD_W-2:0], i_serial_in_pin} : shift_reg;

  // Only the system reset clears the word; the link clock may be stopped at release,
  // so this reset is not synchronised to it
  always_ff @(posedge i_clk_link or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      shift_reg <= WORD_RESET;
    end
    else
    begin
      shift_reg <= shift_next;
    end
  end

  assign o_serial_out_pin = shift_reg[WORD_W-1];

  // Reset goes low at once but leaves on a clock edge
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_reg <= 1'b0;
      sys_rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      sys_rst_n_reg <= rst_meta_reg;
    end
  end

  // Strobe A synchroniser; idles high so no false edge follows reset
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      meta_a_reg <= 1'b1;
      sync_a_reg <= 1'b1;
    end
    else
    begin
      meta_a_reg <= i_load_strobe_a_n;
      sync_a_reg <= meta_a_reg;
    end
  end

  // Strobe B synchroniser; idles high as well
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      meta_b_reg <= 1'b1;
      sync_b_reg <= 1'b1;
    end
    else
    begin
      meta_b_reg <= i_load_strobe_b_n;
      sync_b_reg <= meta_b_reg;
    end
  end

  // Preset pin synchroniser; idles inactive
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      meta_pre_reg <= 1'b1;
      sync_pre_reg <= 1'b1;
    end
    else
    begin
      meta_pre_reg <= i_preset_reset_n;
      sync_pre_reg <= meta_pre_reg;
    end
  end

  // Midscale select synchroniser
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      meta_mid_reg <= 1'b0;
      sync_mid_reg <= 1'b0;
    end
    else
    begin
      meta_mid_reg <= i_midscale_sel;
      sync_mid_reg <= meta_mid_reg;
    end
  end

  // Strobe A history; starts high
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      hist_a_reg <= 1'b1;
    end
    else
    begin
      hist_a_reg <= sync_a_reg;
    end
  end

  // Strobe B history; starts high
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      hist_b_reg <= 1'b1;
    end
    else
    begin
      hist_b_reg <= sync_b_reg;
    end
  end

  // Chip select plays no part here
  assign fall_a = hist_a_reg & ~sync_a_reg;
  assign fall_b = hist_b_reg & ~sync_b_reg;
  assign fall_any = fall_a | fall_b;

  // The host shifts only while both strobes are high, so the link word is still
  // when an edge gets here; it crosses through this one capture, taken on that edge
  assign word_cap_next = fall_any ? shift_reg : word_cap_reg;

  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      word_cap_reg <= WORD_RESET;
    end
    else
    begin
      word_cap_reg <= word_cap_next;
    end
  end

  // Edges are delayed one clock to line up with the captured word
  always_ff @(posedge i_clk_sys or negedge sys_rst_n_reg)
  begin
    if (!sys_rst_n_reg)
    begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end
    else
    begin
      pend_a_reg <= fall_a;
      pend_b_reg <= fall_b;
    end
  end

  // Field view of the captured word
  assign word_view = ddslc_word_s'(word_cap_reg);
  assign hw_mode = ~word_view.mode;
  assign pend_any = pend_a_reg | pend_b_reg;

  // Software mode treats the two strobes as one
  assign sw_load_a = pend_any & word_view.addr_a;
  assign sw_load_b = pend_any & word_view.addr_b;

  // Hardware mode maps each strobe to its own register
  assign sel.load_a = hw_mode ? pend_a_reg : sw_load_a;
  assign sel.load_b = hw_mode ? pend_b_reg : sw_load_b;
  assign load_vec = {sel.load_b, sel.load_a};

  // Zero preset acts at once; half scale is no constant, so it is loaded
  // from the synchronised pins within three system clocks
  assign clr_n = i_nrst & (i_preset_reset_n | i_midscale_sel);
  assign preset_active = ~sync_pre_reg;
  assign preset_code = sync_mid_reg ? CODE_HALF : CODE_ZERO;

  // Channel 0 is register A, channel 1 register B
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    logic [11:0] conv_reg;
    logic [11:0] conv_next;

    // Preset outranks a load in the same clock
    always_comb
    begin
      if (preset_active)
      begin
        conv_next = preset_code;
      end
      else if (load_vec[ch])
      begin
        conv_next = word_view.code;
      end
      else
      begin
        conv_next = conv_reg;
      end
    end

    // Only the zero preset and the system reset act without a clock
    always_ff @(posedge i_clk_sys or negedge clr_n)
    begin
      if (!clr_n)
      begin
        conv_reg <= CODE_ZERO;
      end
      else
      begin
        conv_reg <= conv_next;
      end
    end

    assign conv_q[ch] = conv_reg;
  end : g_chan

  // Outputs come straight from the channel registers
  assign o_conv_reg_a = conv_q[0];
  assign o_conv_reg_b = conv_q[1];
endmodule : ddslc_top
`default_nettype wire

// [dv/ddslc_checker.sv]
// Port checker for the dual converter load control, sampled on the system clock.
// Assumes a bind onto ddslc_top; word_reg mirrors the serial shift word.
`timescale 1ns/1ps
`default_nettype none
module ddslc_checker
  import ddslc_pkg::*;
(
  input wire logic i_clk_sys, i_nrst, i_clk_link, i_cs_n, i_serial_in_pin, o_serial_out_pin,
  input wire logic i_load_strobe_a_n, i_load_strobe_b_n, i_preset_reset_n, i_midscale_sel,
  input wire logic [11:0] o_conv_reg_a, o_conv_reg_b
);
  logic [15:0] word_reg;
  wire logic hw = !word_reg[MODE_BIT] && i_preset_reset_n;
  wire logic sw = word_reg[MODE_BIT] && i_preset_reset_n;
  always_ff @(posedge i_clk_link or negedge i_nrst)
    if (!i_nrst)
      word_reg <= WORD_RESET;
    else if (!i_cs_n)
      word_reg <= {word_reg[14:0], i_serial_in_pin};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Latency is four edges; six gives margin and stays clear of the next load
  property p_load(go, en_a, en_b);
    go |-> ##6 o_conv_reg_a == (en_a ? word_reg[11:0] : $past(o_conv_reg_a, 6))
      && o_conv_reg_b == (en_b ? word_reg[11:0] : $past(o_conv_reg_b, 6));
  endproperty
  a_hw_load_a: assert property (p_load($fell(i_load_strobe_a_n) && i_load_strobe_b_n && hw, 1, 0))
    else $error("hw load A wrong");
  a_hw_load_b: assert property (p_load($fell(i_load_strobe_b_n) && i_load_strobe_a_n && hw, 0, 1))
    else $error("hw load B wrong");
  a_hw_load_both: assert property (p_load($fell(i_load_strobe_a_n) && $fell(i_load_strobe_b_n) && hw, 1, 1))
    else $error("hw load both wrong");
  a_sw_load: assert property (p_load(($fell(i_load_strobe_a_n) || $fell(i_load_strobe_b_n)) && sw,
    word_reg[ADDR_A_BIT], word_reg[ADDR_B_BIT])) else $error("sw load wrong");
  a_preset_zero: assert property ((!i_preset_reset_n && !i_midscale_sel)[*6] |->
    o_conv_reg_a == CODE_ZERO && o_conv_reg_b == CODE_ZERO) else $error("preset zero wrong");
  a_preset_half: assert property ((!i_preset_reset_n && i_midscale_sel)[*6] |->
    o_conv_reg_a == CODE_HALF && o_conv_reg_b == CODE_HALF) else $error("preset half wrong");
  a_hold_value: assert property ((i_load_strobe_a_n && i_load_strobe_b_n && i_preset_reset_n)[*8] |->
    $stable(o_conv_reg_a) && $stable(o_conv_reg_b)) else $error("register drifted");
  a_sdo_stage: assert property (o_serial_out_pin == word_reg[15]) else $error("sdo wrong");
  a_sdo_freeze: assert property (i_cs_n[*3] |-> $stable(o_serial_out_pin)) else $error("shift while off");
  c_hw_both: cover property ($fell(i_load_strobe_a_n) && $fell(i_load_strobe_b_n) && hw);
  c_sw_load: cover property ($fell(i_load_strobe_b_n) && sw);
  c_half: cover property (!i_preset_reset_n && i_midscale_sel);
endmodule : ddslc_checker
`default_nettype wire

// [dv/ddslc_host_model.sv]
// Host model driving the serial link; its clock runs only inside a frame.
// Assumes the bench keeps both load strobes high while send runs.
`timescale 1ns/1ps
`default_nettype none
module ddslc_host_model (
  output logic o_clk_link,
  output logic o_cs_n,
  output logic o_serial_in_pin
);
  initial
  begin
    o_clk_link = 1'b0;
    o_cs_n = 1'b1;
    o_serial_in_pin = 1'b0;
  end
  // A frame with sel_n high is one the device must ignore
  task automatic send(input logic [15:0] word, input logic sel_n);
    #3;
    for (int i = 15; i >= 0; i--)
    begin
      o_cs_n = sel_n;
      o_serial_in_pin = word[i];
      #15 o_clk_link = 1'b1;
      #15 o_clk_link = 1'b0;
    end
    o_cs_n = 1'b1;
    // Released line flips so a stale bit cannot pass
    o_serial_in_pin = ~o_serial_in_pin;
  endtask : send
endmodule : ddslc_host_model
`default_nettype wire

// [dv/ddslc_bench.sv]
// Bench: host model shifts words, bench drives strobes and preset.
// Assumes the design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ddslc_bench
  import ddslc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, la_n = 1'b1, lb_n = 1'b1, pre_n = 1'b1, mid = 1'b0;
  wire logic clk_link, cs_n, serial_in_pin, serial_out_pin;
  wire logic [11:0] ca, cb;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #4 clk = ~clk;
  ddslc_host_model u_ddslc_host_model (.o_clk_link(clk_link), .o_cs_n(cs_n), .o_serial_in_pin(serial_in_pin));
  ddslc_top u_ddslc_top (.i_clk_sys(clk), .i_nrst(nrst), .i_clk_link(clk_link), .i_cs_n(cs_n),
    .i_serial_in_pin(serial_in_pin), .o_serial_out_pin(serial_out_pin), .i_load_strobe_a_n(la_n), .i_load_strobe_b_n(lb_n),
    .i_preset_reset_n(pre_n), .i_midscale_sel(mid), .o_conv_reg_a(ca), .o_conv_reg_b(cb));
  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic regs(input logic [11:0] ea, input logic [11:0] eb);
    #1;
    chk("conv_a", ea, ca);
    chk("conv_b", eb, cb);
  endtask : regs
  task automatic strobe(input logic a_n, input logic b_n);
    repeat (4) @(posedge clk);
    la_n <= a_n;
    lb_n <= b_n;
    repeat (8) @(posedge clk);
    la_n <= 1'b1;
    lb_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : strobe
  task automatic t_hw;
    u_ddslc_host_model.send(16'h05a3, 1'b0);
    strobe(1'b0, 1'b1);
    regs(12'h5a3, 12'h000);
    u_ddslc_host_model.send(16'h1c3e, 1'b0);
    strobe(1'b1, 1'b0);
    regs(12'h5a3, 12'hc3e);
    u_ddslc_host_model.send(16'h0fff, 1'b0);
    strobe(1'b0, 1'b0);
    regs(12'hfff, 12'hfff);
    $display("test hw done");
  endtask : t_hw
  task automatic t_sw;
    logic [11:0] code, ea = 12'hfff, eb = 12'hfff;
    u_ddslc_host_model.send(16'h8001, 1'b0);
    chk("sdo", 12'h001, {11'h000, serial_out_pin});
    u_ddslc_host_model.send(16'h0abc, 1'b1);
    chk("sdo", 12'h001, {11'h000, serial_out_pin});
    strobe(1'b0, 1'b1);
    regs(ea, eb);
    for (int k = 1; k < 4; k++)
    begin
      code = 12'(12'h111 * k);
      u_ddslc_host_model.send({1'b1, k[1:0], 1'b0, code}, 1'b0);
      strobe(k == 2, k != 2);
      if (k[0]) ea = code;
      if (k[1]) eb = code;
      regs(ea, eb);
    end
    $display("test sw done");
  endtask : t_sw
  task automatic t_preset;
    @(posedge clk);
    pre_n <= 1'b0;
    repeat (8) @(posedge clk);
    regs(CODE_ZERO, CODE_ZERO);
    @(posedge clk);
    mid <= 1'b1;
    repeat (8) @(posedge clk);
    regs(CODE_HALF, CODE_HALF);
    @(posedge clk);
    pre_n <= 1'b1;
    repeat (12) @(posedge clk);
    regs(CODE_HALF, CODE_HALF);
    $display("test preset done");
  endtask : t_preset
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_hw();
    t_sw();
    t_preset();
    conclude();
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
endmodule : ddslc_bench
bind ddslc_top ddslc_checker u_ddslc_checker (.i_clk_sys, .i_nrst, .i_clk_link, .i_cs_n, .i_serial_in_pin,
  .o_serial_out_pin, .i_load_strobe_a_n, .i_load_strobe_b_n, .i_preset_reset_n, .i_midscale_sel,
  .o_conv_reg_a, .o_conv_reg_b);
`default_nettype wire
